// ==== hw/rtc_adjust_consts.vh ====
// register indices, field positions and reset values of the adjust block
`ifndef RTC_ADJUST_CONSTS_VH
`define RTC_ADJUST_CONSTS_VH
`define IDX_TIMER_CONTROL 6'h0d
`define IDX_STATUS_FLAGS 6'h0e
`define IDX_SUBSEC_OFFSET_HIGH 6'h19
`define IDX_SUBSEC_OFFSET_LOW 6'h1a
`define IDX_RATE_TRIM_HIGH 6'h1b
`define IDX_RATE_TRIM_LOW 6'h1c
`define IDX_TIMER_CONTROL_ALIAS 6'h1d
`define IDX_STATUS_FLAGS_ALIAS 6'h1e
`define IDX_COUNTER_SELECT 6'h1f
`define IDX_EVENT_INPUT_ENABLE 6'h20
`define IDX_EVENT_PIN1_CONFIG 6'h21
`define IDX_EVENT_PIN2_CONFIG 6'h23
`define RST_TIMER_CONTROL 8'h02
`define MASK_TIMER_CONTROL 8'hfb
`define RST_STATUS_FLAGS 8'hc3
`define RST_COUNTER_SELECT 3'h7
`define RST_PULL_SELECT 3'h2
`define RST_EDGE_SELECT 2'h0
`define PULL_NONE 3'h0
`define PULL_UP_500K 3'h1
`define PULL_UP_1M 3'h2
`define PULL_UP_10M 3'h3
`define PULL_DOWN_500K 3'h4
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define BIT_ACCESS_MODE 2
`define BIT_BIN_ENABLE 1
`define BIT_BCD_ENABLE 0
`define BIT_OFFSET_START 0
`define BIT_TRIM_ENABLE 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== hw/rtc_adjust_counter_select_event_cfg.v ====
// rtc offset, trimming, mirror, counter select and event pin control registers
`timescale 1ns/1ps
`include "rtc_adjust_consts.vh"

module rtc_adjust_counter_select_event_cfg #(
  parameter ADDR_WIDTH = 8,
  parameter NUM_PINS = 2
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr_i,
  input wire [2:0] s_axi_awprot_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr_i,
  input wire [2:0] s_axi_arprot_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire second_tick_i,
  input wire [7:0] status_set_i,
  input wire [NUM_PINS-1:0] event_pin_i,
  output wire offset_apply_o,
  output wire [10:0] subsec_offset_value_o,
  output wire [8:0] rate_trim_value_o,
  output wire rate_trim_enable_o,
  output wire [7:0] timer_control_o,
  output wire [7:0] status_flags_o,
  output wire decimal_access_mode_o,
  output wire binary_seconds_access_o,
  output wire binary_counter_enable_o,
  output wire decimal_counter_enable_o,
  output wire [NUM_PINS-1:0] event_trigger_o,
  output wire [NUM_PINS-1:0] event_capture_o,
  output wire [NUM_PINS-1:0] pull_up_500k_o,
  output wire [NUM_PINS-1:0] pull_up_1m_o,
  output wire [NUM_PINS-1:0] pull_up_10m_o,
  output wire [NUM_PINS-1:0] pull_down_500k_o
);

  // reset release through two flops
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // bus slave state
  reg aw_held_q;
  reg w_held_q;
  reg [5:0] waddr_idx_q;
  reg [7:0] wdata_q;
  reg wlane_q;
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [7:0] rdata_q;
  reg [1:0] rresp_q;

  // register storage
  reg [10:0] offset_q;
  reg [1:0] offset_gp_q;
  reg offset_pending_q;
  reg offset_apply_q;
  reg [8:0] trim_q;
  reg trim_en_q;
  reg [7:0] timer_control_q;
  reg [7:0] flags_q;
  reg [2:0] counter_select_q;
  reg [NUM_PINS-1:0] in_en_q;
  reg [NUM_PINS-1:0] cap_en_q;
  reg [3*NUM_PINS-1:0] pull_q;
  reg [2*NUM_PINS-1:0] edge_q;

  wire aw_take;
  wire w_take;
  wire do_write;
  wire wr_en;
  reg wr_hit;
  reg [7:0] rd_val;
  reg rd_hit;
  wire [5:0] raddr_idx;

  assign aw_take = s_axi_awvalid_i & awready_q;
  assign w_take = s_axi_wvalid_i & wready_q;
  // the write lands once both halves are held and no response is pending
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_en = do_write & wlane_q & wr_hit;
  assign raddr_idx = s_axi_araddr_i[7:2];

  always @*
  begin
    case (waddr_idx_q)
      `IDX_TIMER_CONTROL, `IDX_STATUS_FLAGS, `IDX_SUBSEC_OFFSET_HIGH,
      `IDX_SUBSEC_OFFSET_LOW, `IDX_RATE_TRIM_HIGH, `IDX_RATE_TRIM_LOW,
      `IDX_TIMER_CONTROL_ALIAS, `IDX_STATUS_FLAGS_ALIAS, `IDX_COUNTER_SELECT,
      `IDX_EVENT_INPUT_ENABLE, `IDX_EVENT_PIN1_CONFIG, `IDX_EVENT_PIN2_CONFIG:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_idx_q <= 6'h00;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_q <= 1'b1;
        waddr_idx_q <= s_axi_awaddr_i[7:2];
        awready_q <= 1'b0;
      end
      else if (!aw_held_q && !bvalid_q)
        awready_q <= 1'b1;
      if (w_take)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata_i[7:0];
        wlane_q <= s_axi_wstrb_i[0];
        wready_q <= 1'b0;
      end
      else if (!w_held_q && !bvalid_q)
        wready_q <= 1'b1;
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready_i)
        bvalid_q <= 1'b0;
    end
  end

  // read mux; narrow registers sit in the low byte
  always @*
  begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    case (raddr_idx)
      `IDX_SUBSEC_OFFSET_HIGH:
        rd_val = {offset_q[10], offset_gp_q, offset_q[9:5]};
      `IDX_SUBSEC_OFFSET_LOW:
        rd_val = {offset_q[4:0], 1'b0, ~offset_pending_q, 1'b0};
      `IDX_RATE_TRIM_HIGH:
        rd_val = trim_q[8:1];
      `IDX_RATE_TRIM_LOW:
        rd_val = {trim_q[0], 6'h00, trim_en_q};
      `IDX_TIMER_CONTROL, `IDX_TIMER_CONTROL_ALIAS:
        rd_val = timer_control_q & `MASK_TIMER_CONTROL;
      `IDX_STATUS_FLAGS, `IDX_STATUS_FLAGS_ALIAS:
        rd_val = flags_q;
      `IDX_COUNTER_SELECT:
        rd_val = {5'h00, counter_select_q};
      `IDX_EVENT_INPUT_ENABLE:
        rd_val = {3'h0, cap_en_q[1], cap_en_q[0], 1'b0, in_en_q[1], in_en_q[0]};
      `IDX_EVENT_PIN1_CONFIG:
        rd_val = {3'h0, pull_q[2:0], edge_q[1:0]};
      `IDX_EVENT_PIN2_CONFIG:
        rd_val = {3'h0, pull_q[5:3], edge_q[3:2]};
      default:
        rd_hit = 1'b0;
    endcase
  end

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= `RESP_OKAY;
    end
    else if (s_axi_arvalid_i && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_q)
    begin
      if (s_axi_rready_i)
        rvalid_q <= 1'b0;
    end
    else
      arready_q <= 1'b1;
  end

  // offset correction and register writes
  wire start_wr;
  assign start_wr = wr_en && waddr_idx_q == `IDX_SUBSEC_OFFSET_LOW &&
    wdata_q[`BIT_OFFSET_START];

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      offset_q <= 11'h000;
      offset_gp_q <= 2'h0;
      offset_pending_q <= 1'b0;
      offset_apply_q <= 1'b0;
      trim_q <= 9'h000;
      trim_en_q <= 1'b0;
      timer_control_q <= `RST_TIMER_CONTROL;
      flags_q <= `RST_STATUS_FLAGS;
      counter_select_q <= `RST_COUNTER_SELECT;
      in_en_q <= {NUM_PINS{1'b0}};
      cap_en_q <= {NUM_PINS{1'b0}};
      pull_q <= {NUM_PINS{`RST_PULL_SELECT}};
      edge_q <= {NUM_PINS{`RST_EDGE_SELECT}};
    end
    else
    begin
      // one apply pulse per start; a start in the tick cycle waits for the next
      offset_apply_q <= offset_pending_q & second_tick_i;
      if (start_wr)
        offset_pending_q <= 1'b1;
      else if (second_tick_i)
        offset_pending_q <= 1'b0;
      // hardware flag set wins over a software write
      if (wr_en && (waddr_idx_q == `IDX_STATUS_FLAGS ||
          waddr_idx_q == `IDX_STATUS_FLAGS_ALIAS))
        flags_q <= wdata_q | status_set_i;
      else
        flags_q <= flags_q | status_set_i;
      if (wr_en)
      begin
        case (waddr_idx_q)
          `IDX_SUBSEC_OFFSET_HIGH:
          begin
            offset_q[10] <= wdata_q[7];
            offset_gp_q <= wdata_q[6:5];
            offset_q[9:5] <= wdata_q[4:0];
          end
          `IDX_SUBSEC_OFFSET_LOW:
            offset_q[4:0] <= wdata_q[7:3];
          `IDX_RATE_TRIM_HIGH:
            trim_q[8:1] <= wdata_q;
          `IDX_RATE_TRIM_LOW:
          begin
            trim_q[0] <= wdata_q[7];
            trim_en_q <= wdata_q[`BIT_TRIM_ENABLE];
          end
          `IDX_TIMER_CONTROL, `IDX_TIMER_CONTROL_ALIAS:
            timer_control_q <= wdata_q & `MASK_TIMER_CONTROL;
          `IDX_COUNTER_SELECT:
            counter_select_q <= wdata_q[2:0];
          `IDX_EVENT_INPUT_ENABLE:
          begin
            in_en_q <= wdata_q[1:0];
            cap_en_q <= wdata_q[4:3];
          end
          `IDX_EVENT_PIN1_CONFIG:
          begin
            pull_q[2:0] <= wdata_q[4:2];
            edge_q[1:0] <= wdata_q[1:0];
          end
          `IDX_EVENT_PIN2_CONFIG:
          begin
            pull_q[5:3] <= wdata_q[4:2];
            edge_q[3:2] <= wdata_q[1:0];
          end
          default:
            timer_control_q <= timer_control_q;
        endcase
      end
    end
  end

  // mode outputs, registered so every output leaves a flop
  reg access_mode_q;
  reg bin_access_q;
  reg bin_en_q;
  reg bcd_en_q;

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      access_mode_q <= 1'b1;
      bin_access_q <= 1'b0;
      bin_en_q <= 1'b1;
      bcd_en_q <= 1'b1;
    end
    else
    begin
      access_mode_q <= counter_select_q[`BIT_ACCESS_MODE];
      bin_access_q <= ~counter_select_q[`BIT_ACCESS_MODE];
      bin_en_q <= counter_select_q[`BIT_BIN_ENABLE];
      bcd_en_q <= counter_select_q[`BIT_BCD_ENABLE];
    end
  end

  // per event pin: synchroniser, edge detect, gating, pull decode
  reg [NUM_PINS-1:0] pin_meta_q;
  reg [NUM_PINS-1:0] pin_sync_q;
  reg [NUM_PINS-1:0] pin_prev_q;
  reg [NUM_PINS-1:0] trig_q;
  reg [NUM_PINS-1:0] cap_q;
  reg [NUM_PINS-1:0] pu500_q;
  reg [NUM_PINS-1:0] pu1m_q;
  reg [NUM_PINS-1:0] pu10m_q;
  reg [NUM_PINS-1:0] pd500_q;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : pin
      wire rise;
      wire fall;
      reg hit;
      wire [2:0] psel;
      assign rise = pin_sync_q[g] & ~pin_prev_q[g];
      assign fall = ~pin_sync_q[g] & pin_prev_q[g];
      assign psel = pull_q[3*g+2:3*g];

      always @*
      begin
        case (edge_q[2*g+1:2*g])
          `EDGE_FALL:
            hit = fall;
          `EDGE_RISE:
            hit = rise;
          default:
            hit = rise | fall;
        endcase
      end

      always @(posedge mclk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pin_meta_q[g] <= 1'b0;
          pin_sync_q[g] <= 1'b0;
          pin_prev_q[g] <= 1'b0;
          trig_q[g] <= 1'b0;
          cap_q[g] <= 1'b0;
          pu500_q[g] <= 1'b0;
          pu1m_q[g] <= 1'b1;
          pu10m_q[g] <= 1'b0;
          pd500_q[g] <= 1'b0;
        end
        else
        begin
          pin_meta_q[g] <= event_pin_i[g];
          pin_sync_q[g] <= pin_meta_q[g];
          pin_prev_q[g] <= pin_sync_q[g];
          trig_q[g] <= hit & in_en_q[g];
          cap_q[g] <= hit & in_en_q[g] & cap_en_q[g];
          // unlisted codes fall through to no resistor
          pu500_q[g] <= psel == `PULL_UP_500K;
          pu1m_q[g] <= psel == `PULL_UP_1M;
          pu10m_q[g] <= psel == `PULL_UP_10M;
          pd500_q[g] <= psel == `PULL_DOWN_500K;
        end
      end
    end
  endgenerate

  // offset, trim, mirrors straight from storage flops
  assign subsec_offset_value_o = offset_q;
  assign offset_apply_o = offset_apply_q;
  assign rate_trim_value_o = trim_q;
  assign rate_trim_enable_o = trim_en_q;
  assign timer_control_o = timer_control_q;
  assign status_flags_o = flags_q;
  assign decimal_access_mode_o = access_mode_q;
  assign binary_seconds_access_o = bin_access_q;
  assign binary_counter_enable_o = bin_en_q;
  assign decimal_counter_enable_o = bcd_en_q;
  assign event_trigger_o = trig_q;
  assign event_capture_o = cap_q;
  assign pull_up_500k_o = pu500_q;
  assign pull_up_1m_o = pu1m_q;
  assign pull_up_10m_o = pu10m_q;
  assign pull_down_500k_o = pd500_q;

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = {24'h000000, rdata_q};
  assign s_axi_rresp_o = rresp_q;

endmodule

// ==== verification/event_source.sv ====
// far-side event pin source, idles high as with a pull-up
`timescale 1ns/1ps
module event_source (
  input wire mclk_i,
  input wire [1:0] level_i,
  output reg [1:0] event_pin_o
);
  initial event_pin_o = 2'b11;
  // pins are asynchronous: change a few ns off the edge
  always @(posedge mclk_i)
    event_pin_o <= #3 level_i;
endmodule

// ==== verification/rtc_adjust_chk.sv ====
// assertion checker for the adjust register block
`timescale 1ns/1ps
module rtc_adjust_chk #(
  parameter NUM_PINS = 2
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_rvalid_o,
  input wire [31:0] s_axi_rdata_o,
  input wire second_tick_i,
  input wire offset_apply_o,
  input wire decimal_access_mode_o,
  input wire binary_seconds_access_o,
  input wire binary_counter_enable_o,
  input wire decimal_counter_enable_o,
  input wire [NUM_PINS-1:0] event_trigger_o,
  input wire [NUM_PINS-1:0] event_capture_o,
  input wire [NUM_PINS-1:0] pull_up_500k_o,
  input wire [NUM_PINS-1:0] pull_up_1m_o,
  input wire [NUM_PINS-1:0] pull_up_10m_o,
  input wire [NUM_PINS-1:0] pull_down_500k_o
);
  reg armed_q;
  reg [2:0] wr_age_q;
  // any write may carry a start; weaker but needs no data decode
  always @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i)
      armed_q <= 1'b0;
    else if (s_axi_awvalid_i && s_axi_awready_o)
      armed_q <= 1'b1;
    else if (offset_apply_o)
      armed_q <= 1'b0;
  always @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i)
      wr_age_q <= 3'h7;
    else if (s_axi_awvalid_i && s_axi_awready_o)
      wr_age_q <= 3'h0;
    else if (wr_age_q != 3'h7)
      wr_age_q <= wr_age_q + 3'h1;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  rdata_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  offset_cause_a: assert property ($rose(offset_apply_o) |-> $past(second_tick_i))
    else $error("offset applied without second tick");
  offset_once_a: assert property (offset_apply_o |-> armed_q)
    else $error("offset applied twice");
  mode_pair_a: assert property (binary_seconds_access_o != decimal_access_mode_o)
    else $error("binary access not inverse of mode");
  pull_onehot_a: assert property ($onehot0({pull_up_500k_o[0], pull_up_1m_o[0],
    pull_up_10m_o[0], pull_down_500k_o[0]}))
    else $error("several pull controls on");
  capture_gate_a: assert property ((event_capture_o & ~event_trigger_o) == 0)
    else $error("capture without trigger");
  mode_write_a: assert property ($changed(decimal_access_mode_o) |-> wr_age_q < 3'h6)
    else $error("mode changed without write");
  cnt_enable_a: assert property ($changed({binary_counter_enable_o,
    decimal_counter_enable_o}) |-> wr_age_q < 3'h6)
    else $error("counter enable changed without write");
endmodule
bind rtc_adjust_counter_select_event_cfg rtc_adjust_chk #(.NUM_PINS(NUM_PINS)) chk_i (
  .mclk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_rvalid_o, .s_axi_rdata_o,
  .second_tick_i, .offset_apply_o, .decimal_access_mode_o, .binary_seconds_access_o,
  .binary_counter_enable_o, .decimal_counter_enable_o, .event_trigger_o, .event_capture_o,
  .pull_up_500k_o, .pull_up_1m_o, .pull_up_10m_o, .pull_down_500k_o);

// ==== verification/tb_top.sv ====
// self-checking bench for the adjust register block
`timescale 1ns/1ps
`include "rtc_adjust_consts.vh"
module tb_top;
  reg mclk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [7:0] awaddr = 8'h0, araddr = 8'h0, sset = 8'h0;
  reg [31:0] wdata = 32'h0, seed, r;
  reg [3:0] wstrb = 4'hf;
  reg awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, tk = 1'b0;
  reg [1:0] lvl = 2'b11;
  reg [5:0] a;
  integer mismatches = 0, n_compared = 0, j, k, n, napp = 0, eapp = 0;
  integer ntr [0:1], ncp [0:1], etr [0:1], ecp [0:1];
  wire awready, wready, bvalid, arready, rvalid, apply, trim_en, mode, binacc, binen, bcden;
  wire [1:0] bresp, rresp, pin, trig, cap, pu5, pu1, pu10, pd5;
  wire [31:0] rdata;
  wire [10:0] ofs;
  wire [8:0] trim;
  wire [7:0] flags;
  event_source src (.mclk_i(mclk_i), .level_i(lvl), .event_pin_o(pin));
  rtc_adjust_counter_select_event_cfg dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr),
    .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .second_tick_i(tk), .status_set_i(sset), .event_pin_i(pin),
    .offset_apply_o(apply), .subsec_offset_value_o(ofs), .rate_trim_value_o(trim),
    .rate_trim_enable_o(trim_en), .timer_control_o(), .status_flags_o(flags),
    .decimal_access_mode_o(mode), .binary_seconds_access_o(binacc),
    .binary_counter_enable_o(binen), .decimal_counter_enable_o(bcden),
    .event_trigger_o(trig), .event_capture_o(cap), .pull_up_500k_o(pu5),
    .pull_up_1m_o(pu1), .pull_up_10m_o(pu10), .pull_down_500k_o(pd5));
  initial
    forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    napp <= napp + apply;
    ntr[0] <= ntr[0] + trig[0];
    ntr[1] <= ntr[1] + trig[1];
    ncp[0] <= ncp[0] + cap[0];
    ncp[1] <= ncp[1] + cap[1];
  end
  task chk(input [31:0] s, input [31:0] e);
  begin
    n_compared = n_compared + 1;
    if (s !== e)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  end
  endtask
  task wr(input [5:0] ad, input [7:0] d, input [1:0] e);
  begin
    awaddr <= {ad, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(bresp, e);
  end
  endtask
  task rd(input [5:0] ad, input [7:0] d, input [1:0] e);
  begin
    araddr <= {ad, 2'h0};
    arvalid <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, {24'h0, d});
    chk(rresp, e);
  end
  endtask
  task tick;
  begin
    tk <= 1'b1;
    @(posedge mclk_i);
    tk <= 1'b0;
    repeat (3) @(posedge mclk_i);
  end
  endtask
  function [1:0] ok(input [5:0] x);
    ok = (x == 6'h0d || x == 6'h0e || (x >= 6'h19 && x <= 6'h21) || x == 6'h23) ?
      `RESP_OKAY : `RESP_SLVERR;
  endfunction
  function [7:0] rst_exp(input [5:0] x);
    case (x)
      6'h1a: rst_exp = 8'h02;
      6'h0d, 6'h1d: rst_exp = `RST_TIMER_CONTROL;
      6'h0e, 6'h1e: rst_exp = `RST_STATUS_FLAGS;
      6'h1f: rst_exp = {5'h0, `RST_COUNTER_SELECT};
      6'h21, 6'h23: rst_exp = {3'h0, `RST_PULL_SELECT, `RST_EDGE_SELECT};
      default: rst_exp = 8'h00;
    endcase
  endfunction
  // none for codes 0 and 5..7
  function [3:0] pull_exp(input [2:0] p);
    pull_exp = (p == 3'h0 || p > 3'h4) ? 4'h0 : 4'h1 << (p - 3'h1);
  endfunction
  task summarize;
  begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    mismatches = mismatches + 1;
    summarize;
  end
  initial
  begin
    seed = 32'hb67e633a;
    for (k = 0; k < 2; k = k + 1)
    begin
      ntr[k] = 0;
      ncp[k] = 0;
      etr[k] = 0;
      ecp[k] = 0;
    end
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (a = 6'h0c; a < 6'h25; a = a + 1)
      rd(a, rst_exp(a), ok(a));
    r = $random(seed);
    wr(6'h1d, r[7:0], `RESP_OKAY);
    rd(6'h0d, r[7:0] & `MASK_TIMER_CONTROL, `RESP_OKAY);
    wr(6'h0e, r[15:8], `RESP_OKAY);
    rd(6'h1e, r[15:8], `RESP_OKAY);
    wr(6'h1e, 8'h00, `RESP_OKAY);
    sset <= 8'h24;
    @(posedge mclk_i);
    sset <= 8'h00;
    rd(6'h0e, 8'h24, `RESP_OKAY);
    chk(flags, 8'h24);
    for (j = 0; j < 4; j = j + 1)
    begin
      r = $random(seed);
      wr(6'h19, r[7:0], `RESP_OKAY);
      wr(6'h1a, {r[15:11], 3'h7}, `RESP_OKAY);
      rd(6'h1a, {r[15:11], 3'h0}, `RESP_OKAY);
      chk(ofs, {r[7], r[4:0], r[15:11]});
      tick;
      eapp = eapp + 1;
      chk(napp, eapp);
      rd(6'h1a, {r[15:11], 3'h2}, `RESP_OKAY);
      tick;
      wr(6'h1a, {r[15:11], 3'h0}, `RESP_OKAY);
      tick;
      chk(napp, eapp);
      wr(6'h1b, r[23:16], `RESP_OKAY);
      wr(6'h1c, r[31:24], `RESP_OKAY);
      rd(6'h1c, r[31:24] & 8'h81, `RESP_OKAY);
      chk(trim, {r[23:16], r[31]});
      chk(trim_en, r[24]);
    end
    for (j = 0; j < 8; j = j + 1)
    begin
      r = $random(seed);
      wr(6'h1f, {r[7:3], j[2:0]}, `RESP_OKAY);
      rd(6'h1f, {5'h0, j[2:0]}, `RESP_OKAY);
      chk({mode, binacc, binen, bcden}, {j[2], !j[2], j[1], j[0]});
    end
    for (j = 0; j < 32; j = j + 1)
    begin
      wr(6'h21, {3'h5, j[4:0]}, `RESP_OKAY);
      wr(6'h23, {3'h7, ~j[4:0]}, `RESP_OKAY);
      rd(6'h21, {3'h0, j[4:0]}, `RESP_OKAY);
      chk({pd5[0], pu10[0], pu1[0], pu5[0]}, pull_exp(j[4:2]));
      chk({pd5[1], pu10[1], pu1[1], pu5[1]}, pull_exp(~j[4:2]));
    end
    for (j = 0; j < 12; j = j + 1)
    begin
      r = $random(seed);
      wr(6'h21, {6'h02, j[1:0]}, `RESP_OKAY);
      wr(6'h23, {6'h02, j[1:0]}, `RESP_OKAY);
      wr(6'h20, r[7:0], `RESP_OKAY);
      lvl <= 2'b00;
      repeat (10) @(posedge mclk_i);
      lvl <= 2'b11;
      repeat (10) @(posedge mclk_i);
      for (k = 0; k < 2; k = k + 1)
      begin
        n = r[k] * (1 + j[1]);
        etr[k] = etr[k] + n;
        ecp[k] = ecp[k] + n * r[k + 3];
        chk(ntr[k], etr[k]);
        chk(ncp[k], ecp[k]);
      end
    end
    wstrb <= 4'h0;
    wr(6'h20, 8'h1b, `RESP_OKAY);
    rd(6'h20, r[7:0] & 8'h1b, `RESP_OKAY);
    wstrb <= 4'hf;
    wr(6'h22, 8'hff, `RESP_SLVERR);
    rd(6'h22, 8'h00, `RESP_SLVERR);
    summarize;
  end
endmodule
